// ### core/flm_top.sv
// Memory map decoder with boot remap, plus the flash lock-region guard.
// Assumes a flash programming engine that takes eng_req/eng_cmd and pulses eng_done,
// and a bus fabric that routes accesses according to the registered decode.
`timescale 1ns/1ps
module flm_top
    import flm_pkg::*;
#(
    parameter int SRAM_KB    = 64,   // SRAM size in Kbytes: 64, 32, 16, 8 or 4.
    parameter int FLASH_KB   = 512,  // Flash size in Kbytes: 512 down to 16.
    parameter int PAGE_BYTES = 256   // Flash page size: 256 or 128.
) (
    input  wire logic        sys_clk,     // System clock, 10 MHz.
    input  wire logic        rst,         // Synchronous reset, active high.
    input  wire logic        clk_en,      // Clock enable; all state holds while low.
    input  wire logic        acc_valid,   // Bus access present this cycle.
    input  wire logic [31:0] acc_addr,    // Bus access byte address.
    output logic             dec_valid_q, // Decode result valid.
    output flm_dec_t         dec_q,       // Decode result: selects and offset.
    input  wire logic [4:0]  reg_addr,    // Register byte address.
    input  wire logic [31:0] reg_wdata,   // Register write data.
    input  wire logic        reg_wr,      // Register write strobe.
    input  wire logic        reg_rd,      // Register read strobe.
    output logic      [31:0] reg_rdata_q, // Read data, one cycle after the strobe.
    input  wire logic        chip_wipe,   // External chip-wipe pin, active high.
    output logic             eng_req,     // Request to the programming engine.
    output flm_cmd_t         eng_cmd,     // Command for the programming engine.
    input  wire logic        eng_done,    // Engine finished, one-cycle pulse.
    output logic             irq          // Lock error interrupt.
);

    // Geometry derived from the build parameters.
    localparam int NUM_BANKS    = (FLASH_KB > BANK_KB) ? 2 : 1;          // [R6]
    localparam int REGION_PAGES = (PAGE_BYTES == 256) ? 64 : 32;         // [R8] [R9]
    localparam int REGION_SHIFT = $clog2(REGION_PAGES);
    localparam int NUM_PAGES    = (FLASH_KB * 1024) / PAGE_BYTES;
    localparam int NUM_LOCKS    = NUM_PAGES / REGION_PAGES;
    localparam logic [19:0] SRAM_MASK  = 20'(SRAM_KB * 1024 - 1);        // [R5]
    localparam logic [19:0] FLASH_MASK = 20'(FLASH_KB * 1024 - 1);
    localparam logic [PAGE_W-1:0] PAGE_MASK = PAGE_W'(NUM_PAGES - 1);
    localparam logic [5:0] NUM_LOCKS_W = 6'(NUM_LOCKS);

    logic        remap_q;
    logic        remap_d;
    logic        lockie_q;
    logic        lockie_d;
    logic        lockv_q;
    logic        lockv_d;
    logic [31:0] reg_rdata_d;
    flm_dec_t    dec_d;
    flm_state_t  state_q;
    flm_state_t  state_d;
    flm_cmd_t    cmd_q;
    flm_cmd_t    cmd_d;
    logic        viol_set;
    logic        set_en;
    logic        clr_en;
    logic        cmd_wr;
    logic        region_hit;
    logic [4:0]  lock_idx;
    logic [MAX_BANKS*LOCKS_PER_BANK-1:0] lock_vec;

    // Address decode: flash and SRAM windows, base zero by remap, abort elsewhere in the internal area.
    always_comb begin
        dec_d = '0;
        if (acc_valid && acc_addr[31:28] == INT_AREA) begin
            if (acc_addr[31:20] == WIN_FLASH ||
                (acc_addr[31:20] == WIN_LOW && !remap_q)) begin
                dec_d.flash_sel = 1'b1;                                  // [R2]
                dec_d.offset    = acc_addr[19:0] & FLASH_MASK;           // [R16]
            end else if (acc_addr[31:20] == WIN_SRAM ||
                         (acc_addr[31:20] == WIN_LOW && remap_q)) begin
                dec_d.sram_sel = 1'b1;                                   // [R1]
                dec_d.offset   = acc_addr[19:0] & SRAM_MASK;             // [R16]
            end else begin
                dec_d.abort = 1'b1;                                      // [R3] [R4]
            end
        end
    end

    // Decode register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dec_q       <= '0;
            dec_valid_q <= 1'b0;
        end else if (clk_en) begin
            dec_q       <= dec_d;
            dec_valid_q <= acc_valid;
        end
    end

    // Lock bit lookup for the latched page, wrapped to the flash size.
    always_comb begin
        lock_idx   = 5'((cmd_q.page & PAGE_MASK) >> REGION_SHIFT);       // [R8] [R9]
        region_hit = ({1'b0, lock_idx} < NUM_LOCKS_W) && lock_vec[lock_idx];
    end

    // One lock store per bank, each owning sixteen bits.
    for (genvar b = 0; b < MAX_BANKS; b++) begin : g_bank
        if (b < NUM_BANKS) begin : g_on
            flm_lock_store u_store (                                     // [R7]
                .sys_clk (sys_clk),
                .clk_en  (clk_en),
                .wipe    (chip_wipe),
                .set_en  (set_en && lock_idx[4] == 1'(b)),
                .clr_en  (clr_en && lock_idx[4] == 1'(b)),
                .idx     (lock_idx[3:0]),
                .bits_q  (lock_vec[b*LOCKS_PER_BANK +: LOCKS_PER_BANK])
            );
        end else begin : g_off
            assign lock_vec[b*LOCKS_PER_BANK +: LOCKS_PER_BANK] = '0;
        end
    end

    // Command controller: latch, check against the locks, then run or abort.
    always_comb begin
        state_d  = state_q;
        cmd_d    = cmd_q;
        viol_set = 1'b0;
        set_en   = 1'b0;
        clr_en   = 1'b0;
        cmd_wr   = reg_wr && reg_addr == REG_CMD;
        unique case (state_q)
            ST_IDLE: begin
                if (cmd_wr) begin
                    cmd_d.op   = flm_op_t'(reg_wdata[CMD_OP_LSB +: 4]);
                    cmd_d.page = reg_wdata[CMD_PAGE_LSB +: PAGE_W];
                    state_d    = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_d = ST_IDLE;
                case (cmd_q.op)
                    OP_PROG: begin
                        if (region_hit) begin
                            viol_set = 1'b1;                             // [R10]
                        end else begin
                            state_d = ST_BUSY;
                        end
                    end
                    OP_ERASE: begin
                        if (|lock_vec) begin
                            viol_set = 1'b1;                             // [R10]
                        end else begin
                            state_d = ST_BUSY;
                        end
                    end
                    OP_SETLOCK: set_en = ({1'b0, lock_idx} < NUM_LOCKS_W); // [R12]
                    OP_CLRLOCK: clr_en = ({1'b0, lock_idx} < NUM_LOCKS_W); // [R13]
                    default:    state_d = ST_IDLE;
                endcase
            end
            ST_BUSY: begin
                if (eng_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;                                  // Illegal or unset code.
        endcase
    end

    // Controller state register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q   <= '{op: OP_PROG, page: '0};
        end else if (clk_en) begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
        end
    end

    // Engine handshake: request holds until the done pulse.
    assign eng_req = (state_q == ST_BUSY);
    assign eng_cmd = cmd_q;

    // Register file: mode, status with read-to-clear flag, remap and lock view.
    always_comb begin
        lockie_d    = lockie_q;
        remap_d     = remap_q;
        lockv_d     = lockv_q;
        reg_rdata_d = '0;
        if (reg_wr && reg_addr == REG_MODE) begin
            lockie_d = reg_wdata[MODE_LOCKIE_BIT];
        end
        if (reg_wr && reg_addr == REG_REMAP && reg_wdata[REMAP_BIT]) begin
            remap_d = 1'b1;                                              // [R17]
        end
        if (reg_rd && reg_addr == REG_STAT) begin
            lockv_d = 1'b0;
        end
        if (viol_set) begin
            lockv_d = 1'b1;                                              // [R10]
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_MODE:  reg_rdata_d[MODE_LOCKIE_BIT] = lockie_q;
                REG_STAT: begin
                    reg_rdata_d[STAT_READY_BIT] = (state_q == ST_IDLE);
                    reg_rdata_d[STAT_LOCKV_BIT] = lockv_q;
                end
                REG_CMD: begin
                    reg_rdata_d[CMD_OP_LSB +: 4]        = cmd_q.op;
                    reg_rdata_d[CMD_PAGE_LSB +: PAGE_W] = cmd_q.page;
                end
                REG_REMAP: reg_rdata_d[REMAP_BIT] = remap_q;
                REG_LOCK:  reg_rdata_d = lock_vec;
                default:   reg_rdata_d = '0;
            endcase
        end
    end

    // Register state; only reset returns base zero to flash.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lockie_q    <= MODE_LOCKIE_RST;
            remap_q     <= REMAP_RST;                                    // [R17]
            lockv_q     <= LOCKV_RST;
            reg_rdata_q <= '0;
        end else if (clk_en) begin
            lockie_q    <= lockie_d;
            remap_q     <= remap_d;
            lockv_q     <= lockv_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Interrupt is the flag gated by its enable.
    assign irq = lockv_q && lockie_q;                                    // [R11]

    // Checks on the decode and on the lock guard.
    chk_flash_window: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        clk_en && acc_valid && acc_addr[31:20] == WIN_FLASH
        |=> dec_valid_q && dec_q.flash_sel && !dec_q.sram_sel)
        else $error("flash window not selected");

    chk_boot_low: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        clk_en && acc_valid && acc_addr[31:20] == WIN_LOW && !remap_q
        |=> dec_q.flash_sel)
        else $error("base zero not flash before remap");

    chk_remap_low: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
        clk_en && acc_valid && acc_addr[31:20] == WIN_LOW && remap_q
        |=> dec_q.sram_sel && !dec_q.flash_sel)
        else $error("base zero not SRAM after remap");

    chk_sram_alias: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
        clk_en && acc_valid && acc_addr[31:20] == WIN_SRAM
        |=> dec_q.sram_sel && dec_q.offset == ($past(acc_addr[19:0]) & SRAM_MASK))
        else $error("SRAM offset not wrapped");

    chk_abort_area: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
        clk_en && acc_valid && acc_addr[31:28] == INT_AREA && acc_addr[27:20] > 8'h02
        |=> dec_q.abort && !dec_q.flash_sel && !dec_q.sram_sel)
        else $error("undefined area not aborted");

    chk_remap_sticky: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
        remap_q |=> remap_q)
        else $error("remap dropped without reset");

    chk_locked_abort: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
        clk_en && state_q == ST_CHECK && cmd_q.op == OP_PROG && region_hit
        |=> lockv_q && state_q == ST_IDLE ##1 !eng_req)
        else $error("locked program not aborted");

    chk_irq_gate: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
        !lockie_q |-> !irq)
        else $error("interrupt without enable");

    chk_set_lock: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
        clk_en && state_q == ST_CHECK && cmd_q.op == OP_SETLOCK && !chip_wipe
        && {1'b0, lock_idx} < NUM_LOCKS_W
        |=> lock_vec[$past(lock_idx)])
        else $error("set-lock did not set bit");

    chk_wipe_clears: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
        clk_en && chip_wipe |=> lock_vec == '0)
        else $error("wipe left a lock bit set");

    chk_clear_lock: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
        clk_en && state_q == ST_CHECK && cmd_q.op == OP_CLRLOCK && !chip_wipe
        && {1'b0, lock_idx} < NUM_LOCKS_W
        |=> !lock_vec[$past(lock_idx)])
        else $error("clear-lock did not clear bit");

    chk_erase_abort: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
        clk_en && state_q == ST_CHECK && cmd_q.op == OP_ERASE && |lock_vec
        |=> lockv_q && !eng_req)
        else $error("locked erase not aborted");

    chk_lock_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
        !(clk_en && (chip_wipe || state_q == ST_CHECK))
        |=> lock_vec == $past(lock_vec))
        else $error("lock bits changed without a command");

    chk_irq_raise: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
        clk_en && viol_set && lockie_q && !(reg_wr && reg_addr == REG_MODE)
        |=> irq)
        else $error("enabled lock error gave no interrupt");

    cov_remap_access: cover property (@(posedge sys_clk) disable iff (rst)
        remap_q && dec_valid_q && dec_q.sram_sel);
    cov_lock_abort: cover property (@(posedge sys_clk) disable iff (rst)
        viol_set && clk_en ##1 irq);
    cov_prog_done: cover property (@(posedge sys_clk) disable iff (rst)
        eng_req && eng_done && clk_en);
    cov_wipe_frozen: cover property (@(posedge sys_clk) disable iff (rst)
        !clk_en && chip_wipe && |lock_vec);

endmodule : flm_top

// ### core/flm_pkg.sv
// Shared constants, types and register map for the flash lock and remap block.
// Assumes a single 10 MHz system clock and a plain register port on the system side.
//
// Summary of operation
// R1: SRAM answers only at 0x0020_0000 until remap, then also at base zero.
// R2: Flash always answers at 0x0010_0000, and at base zero until remap.
// R3: Boot ROM is never decoded at any address in this map.
// R4: Internal-area addresses from 0x0030_0000 upward return an abort.
// R5: SRAM size is a build parameter: 64, 32, 16, 8 or 4 Kbytes.
// R6: Largest variant has two 256-Kbyte flash banks; others use one bank.
// R7: In dual-bank builds each bank owns its own sixteen lock bits.
// R8: With 256-byte pages a lock region is 64 pages, 16 Kbytes.
// R9: With 128-byte pages a lock region is 32 pages, 4 Kbytes.
// R10: Program or erase on a locked region aborts and raises the lock flag.
// R11: Interrupt rises on a lock error only when its enable bit is one.
// R12: The set-lock command sets the addressed region's lock bit.
// R13: The clear-lock command clears the addressed region's lock bit.
// R14: Lock bits survive reset and change only through flash commands or the chip-wipe pin.
// R15: The chip-wipe pin clears every lock bit.
// R16: Each memory owns a 1-Mbyte window and aliases modulo its size.
// R17: A remap write moves base zero to SRAM; only reset undoes it.
package flm_pkg;

    // Register offsets on the plain register port.
    localparam logic [4:0] REG_MODE  = 5'h00;
    localparam logic [4:0] REG_STAT  = 5'h04;
    localparam logic [4:0] REG_CMD   = 5'h08;
    localparam logic [4:0] REG_REMAP = 5'h0C;
    localparam logic [4:0] REG_LOCK  = 5'h10;

    // Field positions.
    localparam int MODE_LOCKIE_BIT = 2;
    localparam int STAT_READY_BIT  = 0;
    localparam int STAT_LOCKV_BIT  = 2;
    localparam int REMAP_BIT       = 0;
    localparam int CMD_OP_LSB      = 0;
    localparam int CMD_PAGE_LSB    = 8;

    // Reset values of the volatile control state.
    localparam logic MODE_LOCKIE_RST = 1'b0;
    localparam logic REMAP_RST       = 1'b0;
    localparam logic LOCKV_RST       = 1'b0;

    // Address windows, in units of 1 Mbyte, and the internal area tag.
    localparam logic [11:0] WIN_LOW   = 12'h000;
    localparam logic [11:0] WIN_FLASH = 12'h001;
    localparam logic [11:0] WIN_SRAM  = 12'h002;
    localparam logic [3:0]  INT_AREA  = 4'h0;

    // Flash geometry shared by the controller and the lock store.
    localparam int PAGE_W         = 11;
    localparam int LOCKS_PER_BANK = 16;
    localparam int BANK_KB        = 256;
    localparam int MAX_BANKS      = 2;

    // Flash command codes written into the command register.
    typedef enum logic [3:0] {
        OP_PROG    = 4'h1,
        OP_SETLOCK = 4'h2,
        OP_CLRLOCK = 4'h4,
        OP_ERASE   = 4'h8
    } flm_op_t;

    // Command controller states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_BUSY  = 3'b100
    } flm_state_t;

    // Latched flash command.
    typedef struct packed {
        flm_op_t            op;
        logic [PAGE_W-1:0]  page;
    } flm_cmd_t;

    // Registered result of one address decode.
    typedef struct packed {
        logic        flash_sel;
        logic        sram_sel;
        logic        abort;
        logic [19:0] offset;
    } flm_dec_t;

endpackage : flm_pkg

// ### core/flm_lock_store.sv
// Nonvolatile lock bits of one flash bank.
// Assumes the controller presents at most one of set or clear per cycle; wipe comes straight from the pin.
`timescale 1ns/1ps
module flm_lock_store
    import flm_pkg::*;
(
    input  wire logic                      sys_clk,  // System clock.
    input  wire logic                      clk_en,   // Freezes the bits while low.
    input  wire logic                      wipe,     // Chip-wipe pin, clears all bits.
    input  wire logic                      set_en,   // Set the indexed bit.
    input  wire logic                      clr_en,   // Clear the indexed bit.
    input  wire logic [3:0]                idx,      // Region index inside the bank.
    output logic      [LOCKS_PER_BANK-1:0] bits_q    // Stored lock bits.
);

    logic [LOCKS_PER_BANK-1:0] bits_d;

    // Wipe dominates; otherwise a command changes one bit.
    always_comb begin
        bits_d = bits_q;
        if (wipe) begin
            bits_d = '0;                          // [R15]
        end else if (set_en) begin
            bits_d[idx] = 1'b1;                   // [R12]
        end else if (clr_en) begin
            bits_d[idx] = 1'b0;                   // [R13]
        end
    end

    // No reset on purpose: the bits model nonvolatile cells.
    always_ff @(posedge sys_clk) begin            // [R14]
        if (clk_en) begin
            bits_q <= bits_d;
        end
    end

endmodule : flm_lock_store

// ### tb/flm_engine_model.sv
// Behavioural flash programming engine that answers the lock guard's requests.
// Assumes eng_req stays high until the cycle after eng_done is taken.
`timescale 1ns/1ps
module flm_engine_model (
    input  wire logic sys_clk,  // System clock.
    input  wire logic rst,      // Synchronous reset, active high.
    input  wire logic slow,     // Selects the long answer delay.
    input  wire logic eng_req,  // Request from the guard.
    output logic      eng_done  // One-cycle completion pulse.
);
    logic [3:0] cnt_q;

    // Counts the answer delay, then pulses done once per request.
    always_ff @(posedge sys_clk) begin
        if (rst || !eng_req) begin
            cnt_q    <= 4'h0;
            eng_done <= 1'b0;
        end else if (eng_done) begin
            eng_done <= 1'b0;
        end else if (cnt_q == (slow ? 4'h6 : 4'h0)) begin
            eng_done <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : flm_engine_model

// ### tb/flash_lock_and_remap_bench.sv
// Self-checking bench for the lock guard and remap decoder, default dual-bank build.
// Assumes 512 Kbytes of flash in 256-byte pages and 64 Kbytes of SRAM.
`timescale 1ns/1ps
module flash_lock_and_remap_bench;
    import flm_pkg::*;
    logic        sys_clk, rst, clk_en, acc_valid, reg_wr, reg_rd, chip_wipe, slow;
    logic        dec_valid_q, eng_req, eng_done, irq, req_small;
    logic [31:0] acc_addr, reg_wdata, reg_rdata_q, rd_val, seed, ra, rdata_small;
    logic [4:0]  reg_addr;
    logic [10:0] pg;
    flm_dec_t    dec_q;
    flm_cmd_t    eng_cmd;
    int          bad_count, checks_done;

    flm_top dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .dec_valid_q(dec_valid_q), .dec_q(dec_q), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .chip_wipe(chip_wipe), .eng_req(eng_req), .eng_cmd(eng_cmd), .eng_done(eng_done),
        .irq(irq));
    flm_engine_model eng (.sys_clk(sys_clk), .rst(rst), .slow(slow), .eng_req(eng_req),
        .eng_done(eng_done));
    // Small single-bank build, 128-byte pages; it shares every input but eng_done, which takes its own request, so it finishes at once.
    flm_top #(.SRAM_KB(16), .FLASH_KB(64), .PAGE_BYTES(128)) dut_small (.sys_clk(sys_clk),
        .rst(rst), .clk_en(clk_en), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .dec_valid_q(), .dec_q(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata_small), .chip_wipe(chip_wipe),
        .eng_req(req_small), .eng_cmd(), .eng_done(req_small), .irq());

    // Makes the 100 ns system clock.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Xorshift source for repeatable random stimulus.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected decode of one address for the given remap state.
    function automatic flm_dec_t exp_dec(input logic [31:0] a, input logic rm);
        flm_dec_t d;
        d = '0;
        if (a[31:28] == 4'h0) begin
            if (a[27:20] == 8'h01 || (a[27:20] == 8'h00 && !rm)) begin
                d.flash_sel = 1'b1;
                d.offset    = {1'b0, a[18:0]};
            end else if (a[27:20] == 8'h02 || a[27:20] == 8'h00) begin
                d.sram_sel = 1'b1;
                d.offset   = {4'h0, a[15:0]};
            end else begin
                d.abort = 1'b1;
            end
        end
        return d;
    endfunction : exp_dec

    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata_q;
    endtask : rd_reg

    // Presents one access and checks the registered decode.
    task automatic decode(input logic [31:0] a, input logic rm);
        flm_dec_t e;
        e = exp_dec(a, rm);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_addr  <= a;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        #1;
        chk({dec_valid_q, dec_q.flash_sel, dec_q.sram_sel, dec_q.abort},
            {1'b1, e.flash_sel, e.sram_sel, e.abort}, "decode select");
        if (e.flash_sel || e.sram_sel) chk(dec_q.offset, e.offset, "alias offset");
    endtask : decode

    // Issues a flash command and stops two cycles after it is taken.
    task automatic cmd(input flm_op_t op, input logic [10:0] p);
        wr_reg(REG_CMD, {13'h0, p, 4'h0, op});
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : cmd

    task automatic wait_ready();
        for (int i = 0; i < 20; i++) begin
            rd_reg(REG_STAT);
            if (rd_val[STAT_READY_BIT] === 1'b1) break;
        end
        chk(rd_val[STAT_READY_BIT], 1'b1, "ready");
    endtask : wait_ready

    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset

    // Programs one page that is expected to be unlocked.
    task automatic prog_ok(input logic [10:0] p);
        cmd(OP_PROG, p);
        chk(eng_req, 1'b1, "program started");
        chk(eng_cmd, {OP_PROG, p}, "engine command");
        wait_ready();
        chk(eng_req, 1'b0, "program ended");
    endtask : prog_ok

    // Programs one page that is expected to be locked.
    task automatic prog_locked(input logic [10:0] p);
        cmd(OP_PROG, p);
        chk(eng_req, 1'b0, "locked program ran");
        chk(irq, 1'b0, "irq while masked");
        rd_reg(REG_STAT);
        chk(rd_val[STAT_LOCKV_BIT], 1'b1, "lock flag");
    endtask : prog_locked

    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Cuts a hung run short.
    initial begin
        #(20000 * 100);
        bad_count++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        {rst, clk_en, acc_valid, reg_wr, reg_rd, chip_wipe, slow} = 7'b1100010;
        {acc_addr, reg_wdata, reg_addr, bad_count, checks_done} = '0;
        seed = 32'h0000C91F;
        repeat (5) @(posedge sys_clk);
        rst       <= 1'b0;
        chip_wipe <= 1'b0;
        rd_reg(REG_MODE);
        chk(rd_val, 32'h0, "mode reset");
        rd_reg(REG_STAT);
        chk(rd_val, 32'h1, "status reset");
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h0, "wiped locks");
        rd_reg(5'h14);
        chk(rd_val, 32'h0, "unmapped read");
        decode(32'h0FFFFFFF, 1'b0);
        decode(32'h00300000, 1'b0);
        for (int i = 0; i < 40; i++) begin
            ra = rnd();
            if (i % 5 != 0) ra[31:20] = {4'h0, 6'h00, i[1:0]};
            decode(ra, 1'b0);
        end
        // Locks in each bank, then abort paths with and without the interrupt enable.
        pg = 11'(3 * 64) + 11'(rnd() % 64);
        cmd(OP_SETLOCK, pg);
        wait_ready();
        cmd(OP_SETLOCK, 11'(20 * 64));
        wait_ready();
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h00100008, "set locks");
        chk(rdata_small, (32'h1 << (pg / 32)) | 32'h00000100, "small build locks");
        prog_locked(pg);
        chk(irq, 1'b0, "masked irq");
        rd_reg(REG_STAT);
        chk(rd_val[STAT_LOCKV_BIT], 1'b0, "flag cleared by read");
        prog_locked(11'(20 * 64));
        prog_ok(11'(19 * 64 + 63));
        wr_reg(REG_MODE, 32'h4);
        cmd(OP_ERASE, 11'h000);
        chk(eng_req, 1'b0, "locked erase ran");
        chk(irq, 1'b1, "enabled irq");
        rd_reg(REG_STAT);
        chk(irq, 1'b0, "irq after read");
        do_reset();
        wr_reg(REG_LOCK, 32'hFFFFFFFF);
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h00100008, "locks kept over reset");
        cmd(OP_CLRLOCK, 11'(3 * 64));
        wait_ready();
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h00100000, "clear lock");
        slow <= 1'b1;
        prog_ok(pg);
        @(posedge sys_clk);
        clk_en    <= 1'b0;
        chip_wipe <= 1'b1;
        @(posedge sys_clk);
        clk_en    <= 1'b1;
        chip_wipe <= 1'b0;
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h00100000, "wipe while frozen");
        @(posedge sys_clk);
        chip_wipe <= 1'b1;
        @(posedge sys_clk);
        chip_wipe <= 1'b0;
        rd_reg(REG_LOCK);
        chk(rd_val, 32'h0, "wipe");
        prog_ok(11'(20 * 64));
        // Remap: only a one sets it, and only reset takes it back.
        wr_reg(REG_REMAP, 32'h0);
        decode(32'h00001234, 1'b0);
        wr_reg(REG_REMAP, 32'h1);
        rd_reg(REG_REMAP);
        chk(rd_val, 32'h1, "remap state");
        for (int i = 0; i < 6; i++) decode({12'h000, 20'(rnd())}, 1'b1);
        decode(32'h00104321, 1'b1);
        wr_reg(REG_REMAP, 32'h0);
        decode(32'h0000ABCD, 1'b1);
        do_reset();
        decode(32'h0000ABCD, 1'b0);
        wrap_up();
    end
endmodule : flash_lock_and_remap_bench
